// ---- src/rcsp_map.vh ----
/*
 * Register map, field positions, reset values and timing counts of the
 * clock control, status and write-protection block.
 * Assumes: included by bare name from the design file; definitions only.
 */
`ifndef RCSP_MAP_VH
`define RCSP_MAP_VH

// byte offsets on the register port
`define RCSP_OFF_CONTROL    5'h00
`define RCSP_OFF_STATUS     5'h02
// time and date registers live between these offsets
`define RCSP_OFF_TIME_LO    5'h04
`define RCSP_OFF_TIME_HI    5'h0e

// control fields
`define RCSP_CTL_SWR        8
`define RCSP_CTL_DST        6
`define RCSP_CTL_MATCH_HI   3
`define RCSP_CTL_MATCH_LO   2
`define RCSP_CTL_WE_HI      1
`define RCSP_CTL_WE_LO      0

// write-enable field codes
`define RCSP_WE_LOCK        2'h2
`define RCSP_WE_STEP0       2'h0
`define RCSP_WE_STEP1       2'h1
`define RCSP_WE_STEP2       2'h3

// status fields
`define RCSP_ST_BOOT        6
`define RCSP_ST_CLV         5
`define RCSP_ST_LOCK        4
`define RCSP_ST_TOGGLE      3
`define RCSP_ST_ACCESS_DURING_INVALID_FLAG        2
`define RCSP_ST_CDONE       1
`define RCSP_ST_TIME_INVALID_FLAG       0

// reset values and the invalid-window read value
`define RCSP_RST_MATCH      2'h0
`define RCSP_RST_DST        1'b0
`define RCSP_RST_SEQ        4'h1
`define RCSP_READ_INVALID   16'hffff

// timing: oscillator rate, relock times in seconds, done lead in ticks
`define RCSP_OSC_HZ         16'h8000
`define RCSP_RELOCK_S       4'h2
`define RCSP_POWERON_S      4'hf
`define RCSP_DONE_LEAD      16'h0007

`endif

// ---- src/rcsp_ctrl.v ----
/*
 * Control, status and write-protection logic of the real-time clock:
 * software reset, daylight-saving enable, alarm match depth, the lock
 * with its unlock sequence and timed relock, and the status flags.
 * Assumes: osc_tick is a one-cycle pulse per oscillator cycle, already
 * synchronous to mclk; the time counters, alarm and interrupt registers
 * sit outside and take writes from ext_wr and reads via ext_rdata.
 */
// The register addresses and strobed register access were left to the implementer.
//
// Operation
// [R01] soft reset bit clears itself next clock
// [R02] soft reset clears alarm and interrupt registers
// [R03] daylight-saving enable drives automatic adjustment
// [R04] match field selects compared counters
// [R05] write-enable field reads zero; 10 locks
// [R06] unlock only after 00, 01, 11, 10
// [R07] relock after two unlocked seconds
// [R08] start unlocked, lock fifteen seconds after power-on
// [R09] boot flag set by power-on, cleared at standby
// [R10] low voltage: writes ignored, no error
// [R11] lock flag; writes while locked raise error; this block raises none for writes to the control register
// [R12] interval bit toggles at each interval start
// [R13] access during invalid sets bus error flag
// [R14] invalid: time writes dropped, reads all ones
// [R15] invalid flag spans one tick around boundary
// [R16] done flag marks compensation end, write-one clears
// [R17] done flag set seven ticks before end
// [R18] soft reset restores status except boot flag
// [R19] reserved bits ignore writes, read zero
// [R20] while locked only write-enable field writable
// [R21] oscillator events registered before reaching flags
// [R22] relock timers count seconds, restart on unlock
`timescale 1ns/1ps
`include "rcsp_map.vh"

module rcsp_ctrl
#(
  parameter [15:0] OSC_PER_SEC = `RCSP_OSC_HZ
)
(
  // clock and reset
  input  wire        mclk,
  input  wire        rstn,
  // register port
  input  wire [4:0]  bus_addr,
  input  wire [15:0] bus_wdata,
  input  wire        bus_wr,
  input  wire        bus_rd,
  output reg  [15:0] bus_rdata,
  output reg         bus_xfer_err,
  // registers outside this block
  input  wire [15:0] ext_rdata,
  output reg         ext_wr,
  output reg  [4:0]  ext_wr_addr,
  output reg  [15:0] ext_wr_data,
  // oscillator and power events
  input  wire        osc_tick,
  input  wire        cpu_low_voltage,
  input  wire        standby_entry,
  // compensation settings
  input  wire        comp_enable,
  input  wire [7:0]  comp_seconds,
  // controls to the counters and alarm
  output reg         soft_reset,
  output reg         daylight_saving_enable,
  output reg  [1:0]  alarm_match,
  output reg         lock_state_flag,
  output reg         second_tick
);

////////////////////////////////////////////////////////////////////////
// unlock sequence states, one-hot
localparam [3:0] SEQ_IDLE = 4'b0001;
localparam [3:0] SEQ_GOT0 = 4'b0010;
localparam [3:0] SEQ_GOT1 = 4'b0100;
localparam [3:0] SEQ_GOT2 = 4'b1000;

// oscillator-side state
reg        osc_q;
reg [14:0] presc;
reg        time_invalid_flag;
reg [7:0]  comp_sec;
reg        compensation_interval_toggle;
reg        compensation_done_flag;

// lock state
reg [3:0]  seq;
reg [3:0]  next_seq;
reg [3:0]  relock_cnt;
reg [3:0]  relock_lim;

// status flags
reg        boot_source_flag;
reg        access_during_invalid_flag;

// decode
wire        sel_ctl;
wire        sel_st;
wire        sel_time;
wire        sel_ext;
wire        wr_ok;
wire [1:0]  we_code;
wire [15:0] pre_max;
wire [15:0] pre_done;
wire        at_max;
wire        at_done;
wire [7:0]  comp_last;
wire        comp_end;
wire        relock_due;
wire [15:0] ctl_view;
wire [15:0] st_view;

////////////////////////////////////////////////////////////////////////
// address decode
assign sel_ctl  = (bus_addr == `RCSP_OFF_CONTROL);
assign sel_st   = (bus_addr == `RCSP_OFF_STATUS);
assign sel_time = (bus_addr >= `RCSP_OFF_TIME_LO) &&
                  (bus_addr <= `RCSP_OFF_TIME_HI);
assign sel_ext  = !sel_ctl && !sel_st;
assign we_code  = bus_wdata[`RCSP_CTL_WE_HI:`RCSP_CTL_WE_LO];

// a write may change state: supply good, not locked
assign wr_ok = bus_wr && !cpu_low_voltage && !lock_state_flag; // [R10]

////////////////////////////////////////////////////////////////////////
// oscillator tick points inside the second
assign pre_max  = OSC_PER_SEC - 16'h0001;
assign pre_done = pre_max - `RCSP_DONE_LEAD;
assign at_max   = ({1'b0, presc} == pre_max);
assign at_done  = ({1'b0, presc} == pre_done);

// a zero interval length is taken as one second
assign comp_last = (comp_seconds == 8'h00) ? 8'h00
                                           : comp_seconds - 8'h01;
assign comp_end  = comp_enable && (comp_sec == comp_last);

// register the tick once so every flag sees the same edge
always @(posedge mclk or negedge rstn)
begin
  if (!rstn)
    osc_q <= 1'b0;
  else
    osc_q <= osc_tick; // [R21]
end

// prescaler, seconds boundary and invalid window
always @(posedge mclk or negedge rstn)
begin
  if (!rstn)
  begin
    presc             <= 15'h0000;
    second_tick       <= 1'b0;
    time_invalid_flag <= 1'b0;
  end
  else
  begin
    second_tick <= 1'b0;
    if (osc_q) // [R21]
    begin
      if (at_max)
      begin
        presc       <= 15'h0000;
        second_tick <= 1'b1;
        // last tick before boundary then first after: both invalid
        time_invalid_flag <= 1'b1; // [R15]
      end
      else
      begin
        presc <= presc + 15'h0001;
        // one tick before the boundary raises the flag
        time_invalid_flag <= ({1'b0, presc} == pre_max - 16'h0001); // [R15]
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////
// compensation interval: seconds count, toggle and early done
always @(posedge mclk or negedge rstn)
begin
  if (!rstn)
  begin
    comp_sec                     <= 8'h00;
    compensation_interval_toggle <= 1'b0;
    compensation_done_flag       <= 1'b0;
  end
  else
  begin
    if (!comp_enable)
      comp_sec <= 8'h00; // no toggling while disabled [R12]
    else if (osc_q && at_max)
    begin
      if (comp_end)
      begin
        comp_sec <= 8'h00;
        // new interval begins at this boundary
        compensation_interval_toggle <=
          !compensation_interval_toggle; // [R12]
      end
      else
        comp_sec <= comp_sec + 8'h01;
    end
    // set wins over the write-one clear and the soft reset
    if (osc_q && at_done && comp_end)
      compensation_done_flag <= 1'b1; // [R17]
    else if (soft_reset)
      compensation_done_flag <= 1'b0; // [R18]
    else if (wr_ok && sel_st && bus_wdata[`RCSP_ST_CDONE])
      compensation_done_flag <= 1'b0; // [R16]
    if (soft_reset && !(comp_enable && osc_q && at_max && comp_end))
      compensation_interval_toggle <= 1'b0; // [R18]
  end
end

////////////////////////////////////////////////////////////////////////
// unlock sequence recogniser on write-enable field writes
always @*
begin
  next_seq = seq;
  if (bus_wr && sel_ctl && !cpu_low_voltage)
  begin
    case (seq)
      SEQ_IDLE:
        next_seq = (we_code == `RCSP_WE_STEP0) ? SEQ_GOT0 : SEQ_IDLE;
      SEQ_GOT0:
        next_seq = (we_code == `RCSP_WE_STEP1) ? SEQ_GOT1 :
                   (we_code == `RCSP_WE_STEP0) ? SEQ_GOT0 : SEQ_IDLE;
      SEQ_GOT1:
        next_seq = (we_code == `RCSP_WE_STEP2) ? SEQ_GOT2 :
                   (we_code == `RCSP_WE_STEP0) ? SEQ_GOT0 : SEQ_IDLE;
      SEQ_GOT2:
        next_seq = (we_code == `RCSP_WE_STEP0) ? SEQ_GOT0 : SEQ_IDLE;
      default:
        next_seq = SEQ_IDLE;
    endcase
  end
end

// relock fires on the second that reaches the limit
assign relock_due = second_tick &&
                    (relock_cnt + 4'h1 >= relock_lim); // [R22]

// lock flag and relock timer
always @(posedge mclk or negedge rstn)
begin
  if (!rstn)
  begin
    seq             <= `RCSP_RST_SEQ;
    lock_state_flag <= 1'b0; // power-on starts unlocked [R08]
    relock_cnt      <= 4'h0;
    relock_lim      <= `RCSP_POWERON_S; // [R08]
  end
  else
  begin
    seq <= next_seq; // [R06]
    if (bus_wr && sel_ctl && !cpu_low_voltage &&
        we_code == `RCSP_WE_LOCK)
    begin
      if (seq == SEQ_GOT2)
      begin
        // full ordered sequence seen: unlock and restart timer
        lock_state_flag <= 1'b0; // [R06]
        relock_cnt      <= 4'h0; // [R22]
        relock_lim      <= `RCSP_RELOCK_S; // [R07]
      end
      else
        lock_state_flag <= 1'b1; // [R05]
    end
    else if (!lock_state_flag && second_tick)
    begin
      if (relock_due)
        lock_state_flag <= 1'b1; // [R07]
      else
        relock_cnt <= relock_cnt + 4'h1; // [R22]
    end
  end
end

////////////////////////////////////////////////////////////////////////
// control register fields
always @(posedge mclk or negedge rstn)
begin
  if (!rstn)
  begin
    daylight_saving_enable <= `RCSP_RST_DST;
    alarm_match            <= `RCSP_RST_MATCH;
    soft_reset             <= 1'b0;
  end
  else
  begin
    // one-cycle pulse, clears on the next clock
    soft_reset <= wr_ok && sel_ctl && bus_wdata[`RCSP_CTL_SWR]; // [R01]
    if (wr_ok && sel_ctl) // [R20]
    begin
      daylight_saving_enable <= bus_wdata[`RCSP_CTL_DST]; // [R03]
      alarm_match <=
        bus_wdata[`RCSP_CTL_MATCH_HI:`RCSP_CTL_MATCH_LO]; // [R04]
    end
  end
end

////////////////////////////////////////////////////////////////////////
// boot source and bus error flags
always @(posedge mclk or negedge rstn)
begin
  if (!rstn)
  begin
    boot_source_flag           <= 1'b1; // [R09]
    access_during_invalid_flag <= 1'b0;
  end
  else
  begin
    // soft reset leaves the boot flag alone
    if (standby_entry)
      boot_source_flag <= 1'b0; // [R09]
    // a new access wins over the clear
    if ((bus_wr || bus_rd) && time_invalid_flag)
      access_during_invalid_flag <= 1'b1; // [R13]
    else if (soft_reset)
      access_during_invalid_flag <= 1'b0; // [R18]
    else if (wr_ok && sel_st && bus_wdata[`RCSP_ST_ACCESS_DURING_INVALID_FLAG])
      access_during_invalid_flag <= 1'b0; // [R13]
  end
end

////////////////////////////////////////////////////////////////////////
// read views; write-enable bits and reserved bits read as zero
assign ctl_view = {7'h00, 1'b0, 1'b0, daylight_saving_enable,
                   2'b00, alarm_match, 2'b00}; // [R05] [R19]
assign st_view  = {9'h000, boot_source_flag, cpu_low_voltage,
                   lock_state_flag, compensation_interval_toggle,
                   access_during_invalid_flag, compensation_done_flag,
                   time_invalid_flag}; // [R19]

// read data, one cycle after the strobe
always @(posedge mclk or negedge rstn)
begin
  if (!rstn)
    bus_rdata <= 16'h0000;
  else if (bus_rd)
  begin
    if (sel_ctl)
      bus_rdata <= ctl_view;
    else if (sel_st)
      bus_rdata <= st_view;
    else if (sel_time && time_invalid_flag)
      bus_rdata <= `RCSP_READ_INVALID; // [R14]
    else
      bus_rdata <= ext_rdata;
  end
  else
    bus_rdata <= 16'h0000;
end

////////////////////////////////////////////////////////////////////////
// forward writes to the outside registers, registered one cycle;
// a time write in the invalid window ends normally but leaves the time registers unchanged
always @(posedge mclk or negedge rstn)
begin
  if (!rstn)
  begin
    ext_wr       <= 1'b0;
    ext_wr_addr  <= 5'h00;
    ext_wr_data  <= 16'h0000;
    bus_xfer_err <= 1'b0;
  end
  else
  begin
    ext_wr <= wr_ok && sel_ext &&
              !(sel_time && time_invalid_flag); // [R14] [R20]
    if (bus_wr)
    begin
      ext_wr_addr <= bus_addr;
      ext_wr_data <= bus_wdata;
    end
    // locked writes outside the control register fault; low
    // voltage suppresses the error since it makes all writes quiet
    bus_xfer_err <= bus_wr && lock_state_flag && !sel_ctl &&
                    !cpu_low_voltage; // [R11] [R10]
  end
end

// soft_reset pulse clears alarm and interrupt registers outside [R02]

endmodule // rcsp_ctrl

// ---- dv/rcsp_ext_model.sv ----
/* outside time registers and oscillator tick source of rcsp_ctrl
   assumes: one mclk domain, a tick every TICK_DIV mclk cycles */
`timescale 1ns/1ps
module rcsp_ext_model
#(
  parameter TICK_DIV = 8
)
(
  // clock and reset
  input  wire        mclk,
  input  wire        rstn,
  // outside register port
  input  wire [4:0]  bus_addr,
  input  wire        ext_wr,
  input  wire [4:0]  ext_wr_addr,
  input  wire [15:0] ext_wr_data,
  output wire [15:0] ext_rdata,
  // oscillator
  output reg         osc_tick
);
  reg [15:0] mem [0:15];
  reg [7:0]  div;
  integer    i;
  ////////////////////////////////////////
  // word store, preset to an address pattern
  always @(posedge mclk or negedge rstn)
    if (!rstn)
      for (i = 0; i < 16; i = i + 1)
        mem[i] <= {12'ha50, i[3:0]};
    else if (ext_wr)
      mem[ext_wr_addr[4:1]] <= ext_wr_data;
  assign ext_rdata = mem[bus_addr[4:1]];
  // oscillator runs free, so ticks never stop
  always @(posedge mclk or negedge rstn)
    if (!rstn)
    begin
      div      <= 8'h00;
      osc_tick <= 1'b0;
    end
    else
    begin
      div      <= (div == TICK_DIV - 1) ? 8'h00 : div + 8'h01;
      osc_tick <= (div == TICK_DIV - 1);
    end
endmodule // rcsp_ext_model

// ---- dv/rcsp_ctrl_sva.sv ----
/* port checker of rcsp_ctrl: bus, lock and control fields
   assumes: bound to rcsp_ctrl, single mclk domain */
`timescale 1ns/1ps
`include "rcsp_map.vh"
module rcsp_ctrl_sva
(
  // clock and reset
  input wire        mclk,
  input wire        rstn,
  // register port
  input wire [4:0]  bus_addr,
  input wire [15:0] bus_wdata,
  input wire        bus_wr,
  input wire        bus_rd,
  input wire [15:0] bus_rdata,
  input wire        bus_xfer_err,
  // status and controls
  input wire        ext_wr,
  input wire        cpu_low_voltage,
  input wire        soft_reset,
  input wire        daylight_saving_enable,
  input wire [1:0]  alarm_match,
  input wire        lock_state_flag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // write to control, and a write the lock lets through
  wire ctl = bus_wr && bus_addr == `RCSP_OFF_CONTROL;
  wire okw = bus_wr && !lock_state_flag && !cpu_low_voltage;
  wire bad = bus_wr && lock_state_flag && !cpu_low_voltage && !ctl;
  // last three accepted write-enable codes; 00,01,11 arms the unlock
  reg  [5:0] we_hist;
  wire       seq_done = (we_hist == 6'b00_01_11);
  always @(posedge mclk or negedge rstn)
    if (!rstn)
      we_hist <= 6'h3f;
    else if (ctl && !cpu_low_voltage)
      we_hist <= {we_hist[3:0], bus_wdata[1:0]};
  ////////////////////////////////////////
  a_swr_pulse: assert property (soft_reset |=> !soft_reset)
    else $error("soft reset longer than one cycle");
  a_swr_cause: assert property (soft_reset |-> $past(okw && ctl
    && bus_wdata[8]))
    else $error("soft reset without accepted request");
  a_field_take: assert property (okw && ctl |=>
    daylight_saving_enable == $past(bus_wdata[6])
    && alarm_match == $past(bus_wdata[3:2]))
    else $error("control fields not taken");
  a_locked_hold: assert property (bus_wr && lock_state_flag
    && bus_wdata[1:0] != 2'b10 |=> $stable(daylight_saving_enable)
    && $stable(alarm_match))
    else $error("locked control fields changed");
  a_lock_err: assert property (bad |=> bus_xfer_err)
    else $error("locked write without transfer error");
  a_err_cause: assert property (bus_xfer_err |-> $past(bad))
    else $error("transfer error without locked write");
  a_ext_cause: assert property (ext_wr |-> $past(okw))
    else $error("outside write not allowed");
  a_we_lock: assert property (ctl && !cpu_low_voltage
    && !lock_state_flag && bus_wdata[1:0] == 2'b10 && !seq_done
    |=> lock_state_flag)
    else $error("write of lock code did not lock");
  a_unlock_seq: assert property (ctl && !cpu_low_voltage
    && bus_wdata[1:0] == 2'b10 && seq_done |=> !lock_state_flag)
    else $error("completed unlock sequence did not unlock");
  a_ctl_rsvd: assert property ($past(bus_rd && bus_addr == 5'h00)
    |-> (bus_rdata & 16'hffb3) == 16'h0000)
    else $error("control reserved bits not zero");
  a_st_rsvd: assert property ($past(bus_rd && bus_addr == 5'h02)
    |-> bus_rdata[15:7] == 9'h000
    && bus_rdata[4] == $past(lock_state_flag))
    else $error("status read wrong");
  c_swr: cover property (soft_reset);
  c_err: cover property (bus_xfer_err);
  c_lock: cover property ($rose(lock_state_flag));
  c_ext: cover property (ext_wr);
endmodule // rcsp_ctrl_sva
bind rcsp_ctrl rcsp_ctrl_sva i_sva (.mclk(mclk), .rstn(rstn),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
  .bus_rd(bus_rd), .bus_rdata(bus_rdata), .bus_xfer_err(bus_xfer_err),
  .ext_wr(ext_wr), .cpu_low_voltage(cpu_low_voltage),
  .soft_reset(soft_reset), .alarm_match(alarm_match),
  .daylight_saving_enable(daylight_saving_enable),
  .lock_state_flag(lock_state_flag));

// ---- dv/rcsp_ctrl_tb.sv ----
/* self-checking bench of rcsp_ctrl
   assumes: OSC_PER_SEC 16 and a tick every 8 mclk, so 128 per second */
`timescale 1ns/1ps
`include "rcsp_map.vh"
module rcsp_ctrl_tb;
  localparam SEC = 128;
  reg         mclk = 1'b0;
  reg         rstn = 1'b0;
  reg  [4:0]  addr = 5'h00;
  reg  [15:0] wdata = 16'h0000;
  reg         wr = 1'b0;
  reg         rd = 1'b0;
  reg         cpu_low_voltage_flag = 1'b0;
  reg         stby = 1'b0;
  reg         cen = 1'b0;
  reg  [7:0]  csec = 8'h01;
  wire [15:0] rdata, erd, ewd;
  wire [4:0]  ewa;
  wire [1:0]  am;
  wire        xerr, ewr, tick, soft_reset_request, dse, lck, sec;
  reg  [15:0] q;
  reg         tg;
  integer     fails = 0;
  integer     n_tests = 0;
  integer     cyc = 0;
  integer     t0, k;
  ////////////////////////////////////////
  rcsp_ctrl #(.OSC_PER_SEC(16'h0010)) i_dut (.mclk(mclk), .rstn(rstn),
    .bus_addr(addr), .bus_wdata(wdata), .bus_wr(wr), .bus_rd(rd),
    .bus_rdata(rdata), .bus_xfer_err(xerr), .ext_rdata(erd),
    .ext_wr(ewr), .ext_wr_addr(ewa), .ext_wr_data(ewd), .osc_tick(tick),
    .cpu_low_voltage(cpu_low_voltage_flag), .standby_entry(stby), .comp_enable(cen),
    .comp_seconds(csec), .soft_reset(soft_reset_request), .daylight_saving_enable(dse),
    .alarm_match(am), .lock_state_flag(lck), .second_tick(sec));
  rcsp_ext_model #(.TICK_DIV(8)) i_ext (.mclk(mclk), .rstn(rstn),
    .bus_addr(addr), .ext_wr(ewr), .ext_wr_addr(ewa),
    .ext_wr_data(ewd), .ext_rdata(erd), .osc_tick(tick));
  always #12.5 mclk = ~mclk;
  // hang guard, about three times the expected run
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 9000)
    begin
      fails = fails + 1;
      print_verdict;
    end
  end
  ////////////////////////////////////////
  task wr16(input [4:0] a, input [15:0] d);
    begin
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr    <= 1'b0;
    end
  endtask
  task rd16(input [4:0] a);
    begin
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd   <= 1'b0;
      #1 q = rdata;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
        fails = fails + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // bounded wait for lock (s=1) or a seconds boundary (s=0)
  task wait_ev(input s);
    begin
      k = 0;
      while (((s ? lck : sec) !== 1'b1) && k < 3000)
      begin
        @(posedge mclk);
        #1 k = k + 1;
      end
      chk(k < 3000, 1);
    end
  endtask
  task unlock;
    begin
      wr16(5'h00, 16'h0000);
      wr16(5'h00, 16'h0001);
      wr16(5'h00, 16'h0003);
      wr16(5'h00, 16'h0002);
    end
  endtask
  ////////////////////////////////////////
  task t_boot;
    begin
      rd16(5'h02);
      chk(q & 16'hffd0, 16'h0040);
      rd16(5'h00);
      chk(q, 16'h0000);
      $display("t_boot done");
    end
  endtask
  task t_fields;
    begin
      for (k = 0; k < 4; k = k + 1)
      begin
        wr16(5'h00, 16'hfef0 | {12'h000, k[1:0], 2'b00});
        #1 chk(am, k[1:0]);
        chk(dse, 1);
        rd16(5'h00);
        chk(q, 16'h0040 | {12'h000, k[1:0], 2'b00});
      end
      $display("t_fields done");
    end
  endtask
  task t_swr;
    begin
      wr16(5'h00, 16'h014c);
      #1 chk(soft_reset_request, 1);
      @(posedge mclk);
      #1 chk(soft_reset_request, 0);
      rd16(5'h00);
      chk(q, 16'h004c);
      rd16(5'h02);
      chk(q[6], 1);
      @(posedge mclk);
      stby <= 1'b1;
      @(posedge mclk);
      stby <= 1'b0;
      rd16(5'h02);
      chk(q[6], 0);
      $display("t_swr done");
    end
  endtask
  task t_time_invalid_flag;
    integer j;
    begin
      for (j = 0; j < 2; j = j + 1)
      begin
        wait_ev(0);
        rd16(`RCSP_OFF_TIME_LO);
        chk(q, 16'hffff);
        rd16(5'h02);
        chk(q[0], 1);
        repeat (40) @(posedge mclk);
        rd16(`RCSP_OFF_TIME_LO);
        chk(q, 16'ha502);
        rd16(5'h02);
        chk(q & 16'h0005, 16'h0004);
        wr16(j ? 5'h00 : 5'h02, j ? 16'h014c : 16'h0004);
        rd16(5'h02);
        chk(q[2], 0);
      end
      $display("t_time_invalid_flag done");
    end
  endtask
  task t_lock;
    begin
      wait_ev(1);
      chk(cyc - t0 >= 14 * SEC && cyc - t0 <= 16 * SEC, 1);
      wr16(5'h02, 16'h0004);
      #1 chk(xerr, 1);
      wr16(5'h00, 16'h0000);
      #1 chk({xerr, dse}, 2'b01);
      wr16(5'h06, 16'h5555);
      #1 chk({xerr, ewr}, 2'b10);
      wr16(5'h00, 16'h0001);
      wr16(5'h00, 16'h0002);
      #1 chk(lck, 1);
      unlock;
      #1 chk(lck, 0);
      t0 = cyc;
      wait_ev(1);
      chk(cyc - t0 > SEC && cyc - t0 <= 2 * SEC + 8, 1);
      $display("t_lock done");
    end
  endtask
  task t_lowv;
    begin
      unlock;
      cpu_low_voltage_flag <= 1'b1;
      wr16(5'h00, 16'h0002);
      #1 chk({lck, dse}, 2'b01);
      wr16(5'h06, 16'h5555);
      #1 chk({xerr, ewr}, 2'b00);
      rd16(5'h02);
      chk(q[5], 1);
      cpu_low_voltage_flag <= 1'b0;
      wr16(5'h06, 16'h5555);
      #1 chk(ewr, 1);
      chk(ewd, 16'h5555);
      chk({11'h000, ewa}, 16'h0006);
      $display("t_lowv done");
    end
  endtask
  task t_comp;
    begin
      @(posedge mclk);
      cen <= 1'b1;
      wait_ev(0);
      repeat (40) @(posedge mclk);
      // relock may have struck meanwhile; the clear needs write access
      unlock;
      wr16(5'h02, 16'h0002);
      rd16(5'h02);
      chk(q[1], 0);
      tg = q[3];
      repeat (50) @(posedge mclk);
      rd16(5'h02);
      chk(q[1], 1);
      wait_ev(0);
      repeat (40) @(posedge mclk);
      rd16(5'h02);
      chk(q[3], !tg);
      @(posedge mclk);
      cen <= 1'b0;
      wait_ev(0);
      repeat (40) @(posedge mclk);
      rd16(5'h02);
      chk(q[3], !tg);
      $display("t_comp done");
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    t0 = cyc;
    t_boot;
    t_fields;
    t_swr;
    t_time_invalid_flag;
    t0 = t0 + 0;
    t_lock;
    t_lowv;
    t_comp;
    print_verdict;
  end
endmodule // rcsp_ctrl_tb
